// ### logic/ret_rot_pkg.sv
// Package: opcodes, widths, stack sizes and carriers for the return/rotate slice
package ret_rot_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int OPCODE_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int FADDR_W = 7;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;

    // ------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------
    localparam logic [13:0] LIT_RET_MASK = 14'h3c00;
    localparam logic [13:0] LIT_RET_CODE = 14'h3400;
    localparam logic [13:0] SUB_RET_CODE = 14'h0008;
    localparam logic [13:0] ROT_MASK = 14'h3f00;
    localparam logic [13:0] ROT_CODE = 14'h0c00;
    localparam int DEST_BIT = 7;
    localparam int LIT_LSB = 0;
    localparam int FADDR_LSB = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [2:0] SP_RESET = 3'h0;

    typedef enum logic [1:0] {
        ST_FETCH,
        ST_SECOND
    } exec_state_t;

    // Instruction issue carrier
    typedef struct packed {
        logic valid;
        logic [13:0] opcode;
    } instr_t;

    // Register file write carrier
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;

    // Decoded instruction class
    typedef struct packed {
        logic lit_ret;
        logic sub_ret;
        logic rotate;
    } decode_t;

endpackage

// ### logic/return_stack.sv
// Return stack: push from core, pop on returns
`timescale 1ns/10ps
module return_stack
    import ret_rot_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int AW = PC_W
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic push_in,
    input wire logic [AW-1:0] push_addr_in,
    input wire logic pop_in,
    output logic [AW-1:0] stack_head_out,
    output logic [$clog2(DEPTH)-1:0] sp_out
);
    localparam int SW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << SW) != DEPTH) begin : g_depth_check
        $error("DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][AW-1:0] mem;
        logic [SW-1:0] sp;
    } stk_t;

    stk_t s_reg;
    stk_t s_next;

    // ------------------------------------------------------------
    // Next state: circular stack, sp points above the head
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        if (pop_in) begin
            s_next.sp = s_reg.sp - SW'(1); // see (RULE7)
        end else if (push_in) begin
            s_next.mem[s_reg.sp] = push_addr_in;
            s_next.sp = s_reg.sp + SW'(1);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else if (ce_in) begin
            s_reg <= s_next;
        end
    end

    assign stack_head_out = s_reg.mem[s_reg.sp - SW'(1)];
    assign sp_out = s_reg.sp;

    a_pop_moves_back: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // see (RULE7)
        ce_in && pop_in |=> sp_out == $past(sp_out) - SW'(1))
        else $error("Pop did not step stack pointer back by one");

endmodule

// ### logic/return_and_rotate_exec.sv
// Execution slice for literal return, subroutine return and right rotate
// Operation
// (RULE1) A literal-return opcode writes its 8-bit literal, 0 to 255, into the accumulator.
// (RULE2) A literal-return loads the program counter from the stack head and takes two instruction cycles.
// (RULE3) The subroutine-return opcode pops the stack and puts the popped head into the program counter.
// (RULE4) A subroutine return takes two instruction cycles and leaves the status flags alone.
// (RULE5) The rotate shifts register f (0 to 127) right through carry: old carry to bit 7, bit 0 to carry.
// (RULE6) The rotate result goes to the accumulator when the destination bit is 0, else back to register f.
// (RULE7) Each pop moves the stack pointer back one entry so the next return uses the older address.
`timescale 1ns/10ps
module return_and_rotate_exec
    import ret_rot_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire instr_t instr_in,
    input wire logic push_in,
    input wire logic [PC_W-1:0] push_addr_in,
    input wire logic [DATA_W-1:0] file_rdata_in,
    input wire logic carry_in,
    output logic [FADDR_W-1:0] file_raddr_out,
    output file_wr_t file_wr_out,
    output logic [DATA_W-1:0] acc_out,
    output logic carry_out,
    output logic carry_we_out,
    output logic [PC_W-1:0] pc_out,
    output logic pc_load_out,
    output logic busy_out,
    output logic ready_out
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DATA_W != 8 || OPCODE_W != 14 || FADDR_W != 7) begin : g_width_check
        $error("Rotate and literal fields need an 8-bit data path and 14-bit opcodes");
    end
    if (SP_W != $clog2(STACK_DEPTH) || PC_W < 1) begin : g_stack_check
        $error("Stack pointer width does not fit the stack depth");
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic decode_t decode(input logic [13:0] op);
        decode_t d;
        d.lit_ret = (op & LIT_RET_MASK) == LIT_RET_CODE;
        d.sub_ret = op == SUB_RET_CODE;
        d.rotate = (op & ROT_MASK) == ROT_CODE;
        return d;
    endfunction

    function automatic logic [8:0] rot_right(input logic [7:0] v, input logic c);
        return {v[0], c, v[7:1]};
    endfunction

    typedef struct packed {
        exec_state_t state;
        logic [DATA_W-1:0] acc;
        logic carry;
        logic carry_we;
        file_wr_t wr;
        logic [PC_W-1:0] pc;
        logic pc_load;
    } core_t;

    core_t r_reg;
    core_t r_next;
    decode_t dec;
    logic take;
    logic pop;
    logic [8:0] rot;
    logic [PC_W-1:0] head;
    logic [SP_W-1:0] sp;

    assign take = instr_in.valid && r_reg.state == ST_FETCH;
    assign dec = decode(instr_in.opcode);
    assign file_raddr_out = instr_in.opcode[FADDR_LSB +: FADDR_W];
    assign rot = rot_right(file_rdata_in, carry_in); // see (RULE5)
    assign pop = take && (dec.lit_ret || dec.sub_ret); // see (RULE3)

    return_stack #(
        .DEPTH(STACK_DEPTH),
        .AW(PC_W)
    ) u_stack (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .push_in(push_in && !pop),
        .push_addr_in(push_addr_in),
        .pop_in(pop),
        .stack_head_out(head),
        .sp_out(sp)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        // Pulses last one enabled cycle
        r_next.wr.we = 1'b0;
        r_next.carry_we = 1'b0;
        r_next.pc_load = 1'b0;
        unique case (r_reg.state)
            ST_FETCH: begin
                if (take && dec.lit_ret) begin
                    r_next.acc = instr_in.opcode[LIT_LSB +: DATA_W]; // see (RULE1)
                    r_next.pc = head; // see (RULE2)
                    r_next.pc_load = 1'b1;
                    r_next.state = ST_SECOND;
                end else if (take && dec.sub_ret) begin
                    r_next.pc = head; // see (RULE3)
                    r_next.pc_load = 1'b1;
                    r_next.state = ST_SECOND; // see (RULE4)
                end else if (take && dec.rotate) begin
                    r_next.carry = rot[8]; // see (RULE5)
                    r_next.carry_we = 1'b1;
                    if (instr_in.opcode[DEST_BIT]) begin
                        r_next.wr.we = 1'b1; // see (RULE6)
                        r_next.wr.addr = instr_in.opcode[FADDR_LSB +: FADDR_W];
                        r_next.wr.data = rot[7:0];
                    end else begin
                        r_next.acc = rot[7:0]; // see (RULE6)
                    end
                end
            end
            ST_SECOND: begin
                r_next.state = ST_FETCH; // see (RULE2)
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_reg <= '{state: ST_FETCH, acc: ACC_RESET, carry: 1'b0, carry_we: 1'b0,
                       wr: '0, pc: PC_RESET, pc_load: 1'b0};
        end else if (ce_in) begin
            r_reg <= r_next;
        end
    end

    assign acc_out = r_reg.acc;
    assign carry_out = r_reg.carry;
    assign carry_we_out = r_reg.carry_we;
    assign file_wr_out = r_reg.wr;
    assign pc_out = r_reg.pc;
    assign pc_load_out = r_reg.pc_load;
    assign busy_out = r_reg.state == ST_SECOND;
    assign ready_out = r_reg.state == ST_FETCH;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_lit_issue;
        ce_in && take && dec.lit_ret;
    endsequence

    sequence s_ret_issue;
        ce_in && take && dec.sub_ret;
    endsequence

    sequence s_rot_issue;
        ce_in && take && dec.rotate;
    endsequence

    // Second cycle of a return, then fetch again unless frozen
    sequence s_two_cycle;
        busy_out ##1 ($past(ce_in) ? ready_out : busy_out);
    endsequence

    // Literal return
    a_lit_acc_load: assert property (s_lit_issue |=> acc_out == $past(instr_in.opcode[7:0])) // see (RULE1)
        else $error("Literal not loaded into accumulator");
    a_lit_pc_head: assert property (s_lit_issue |=> pc_load_out && pc_out == $past(head)) // see (RULE2)
        else $error("Literal return did not load PC from stack head");
    a_lit_two_cycles: assert property (s_lit_issue |=> s_two_cycle) // see (RULE2)
        else $error("Literal return not two cycles");
    a_lit_flags_kept: assert property (s_lit_issue |=> !carry_we_out ##1 !carry_we_out) // see (RULE2)
        else $error("Literal return touched status flags");
    a_lit_no_write: assert property (s_lit_issue |=> !file_wr_out.we) // see (RULE2)
        else $error("Literal return wrote the register file");

    // Subroutine return
    a_ret_pc_head: assert property (ce_in && take && dec.sub_ret |=> pc_out == $past(head)) // see (RULE3)
        else $error("Return did not load popped head");
    a_ret_flags_kept: assert property (ce_in && take && dec.sub_ret |=> !carry_we_out ##1 !carry_we_out) // see (RULE4)
        else $error("Return touched status flags");
    a_ret_two_cycles: assert property (s_ret_issue |=> s_two_cycle) // see (RULE4)
        else $error("Return not two cycles");
    a_ret_acc_kept: assert property (s_ret_issue |=> $stable(acc_out)) // see (RULE3)
        else $error("Return changed the accumulator");
    a_ret_no_write: assert property (s_ret_issue |=> !file_wr_out.we) // see (RULE4)
        else $error("Return wrote the register file");

    // Rotate
    a_rot_carry_out: assert property (ce_in && take && dec.rotate // see (RULE5)
        |=> carry_we_out && carry_out == $past(file_rdata_in[0]))
        else $error("Rotate carry wrong");
    a_rot_to_acc: assert property (ce_in && take && dec.rotate && !instr_in.opcode[DEST_BIT] // see (RULE6)
        |=> !file_wr_out.we && acc_out == {$past(carry_in), $past(file_rdata_in[7:1])})
        else $error("Rotate result not in accumulator");
    a_rot_to_file: assert property (ce_in && take && dec.rotate && instr_in.opcode[DEST_BIT] // see (RULE6)
        |=> file_wr_out.we && file_wr_out.data == {$past(carry_in), $past(file_rdata_in[7:1])})
        else $error("Rotate result not written back");
    a_rot_file_addr: assert property (ce_in && take && dec.rotate && instr_in.opcode[DEST_BIT] // see (RULE6)
        |=> file_wr_out.addr == $past(instr_in.opcode[FADDR_LSB +: FADDR_W]))
        else $error("Rotate written to wrong register");
    a_rot_acc_kept: assert property (ce_in && take && dec.rotate && instr_in.opcode[DEST_BIT] // see (RULE6)
        |=> $stable(acc_out))
        else $error("Rotate to register changed the accumulator");
    a_rot_one_cycle: assert property (s_rot_issue |=> ready_out && !pc_load_out) // see (RULE5)
        else $error("Rotate did not finish in one cycle");

    // Stack, refusal and clock enable
    a_pop_sp_back: assert property (ce_in && pop |=> sp == $past(sp) - 3'h1) // see (RULE7)
        else $error("Pop did not move stack pointer back");
    a_busy_refuses: assert property (busy_out && ce_in // see (RULE4)
        |=> ready_out && !pc_load_out && !carry_we_out && !file_wr_out.we)
        else $error("Instruction taken during second return cycle");
    a_ce_freeze_pc: assert property (!ce_in // see (RULE2)
        |=> $stable(pc_out) && $stable(pc_load_out) && $stable(busy_out))
        else $error("Program counter state moved with clock enable low");
    a_ce_freeze_acc: assert property (!ce_in // see (RULE7)
        |=> $stable(acc_out) && $stable(carry_out) && $stable(file_wr_out) && $stable(sp))
        else $error("Data state moved with clock enable low");

endmodule

// ### sim/return_and_rotate_exec_test.sv
// Self-checking bench for the return and rotate execution slice
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module return_and_rotate_exec_test;
    import ret_rot_pkg::*;

    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce_in = 1'b1;
    instr_t instr_in = '0;
    logic push_in = 1'b0;
    logic [PC_W-1:0] push_addr_in = '0;
    logic [DATA_W-1:0] file_rdata_in = '0;
    logic carry_in = 1'b0;
    logic [FADDR_W-1:0] file_raddr_out;
    file_wr_t file_wr_out;
    logic [DATA_W-1:0] acc_out;
    logic carry_out, carry_we_out, pc_load_out, busy_out, ready_out;
    logic [PC_W-1:0] pc_out;
    int fails = 0;
    int checked = 0;
    // Behavioural model state
    logic [PC_W-1:0] stk [8];
    int sp = 0;
    logic [7:0] acc_m = 8'h00;

    return_and_rotate_exec dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .instr_in(instr_in), .push_in(push_in), .push_addr_in(push_addr_in), .file_rdata_in(file_rdata_in),
        .carry_in(carry_in), .file_raddr_out(file_raddr_out), .file_wr_out(file_wr_out), .acc_out(acc_out),
        .carry_out(carry_out), .carry_we_out(carry_we_out), .pc_out(pc_out), .pc_load_out(pc_load_out),
        .busy_out(busy_out), .ready_out(ready_out));

    always #12.5 clk_sys_in = ~clk_sys_in;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n_in = 1'b0;
        for (int i = 0; i < 8; i++) stk[i] = '0;
        sp = 0;
        acc_m = 8'h00;
        repeat (10) @(posedge clk_sys_in);
        #2;
        `CHK("acc reset", 8'h00, acc_out)
        `CHK("pc reset", 13'h0000, pc_out)
        `CHK("ready reset", 1'b1, ready_out)
        `CHK("pc_load reset", 1'b0, pc_load_out)
        rst_n_in = 1'b1;
    endtask

    task automatic do_push(input logic [PC_W-1:0] a);
        push_in = 1'b1;
        push_addr_in = a;
        stk[sp] = a;
        sp = (sp + 1) % 8;
        @(posedge clk_sys_in);
        #2;
        push_in = 1'b0;
        @(posedge clk_sys_in);
        #2;
    endtask

    task automatic do_ret(input logic lit, input logic [7:0] k, input logic [1:0] xx);
        logic [PC_W-1:0] h;
        sp = (sp + 7) % 8;
        h = stk[sp];
        instr_in = lit ? {1'b1, 4'hd, xx, k} : {1'b1, SUB_RET_CODE};
        if (lit) acc_m = k;
        @(posedge clk_sys_in);
        #2;
        `CHK("acc", acc_m, acc_out)
        `CHK("pc", h, pc_out)
        `CHK("pc_load", 1'b1, pc_load_out)
        `CHK("busy", 1'b1, busy_out)
        `CHK("ready", 1'b0, ready_out)
        `CHK("carry_we", 1'b0, carry_we_out)
        // Rotate offered while busy must be refused
        instr_in = {1'b1, 6'h0c, 1'b0, 7'h05};
        file_rdata_in = 8'hff;
        @(posedge clk_sys_in);
        #2;
        `CHK("pc_load second", 1'b0, pc_load_out)
        `CHK("ready second", 1'b1, ready_out)
        `CHK("refused rotate", 1'b0, carry_we_out)
        `CHK("acc kept", acc_m, acc_out)
        instr_in.valid = 1'b0;
        @(posedge clk_sys_in);
        #2;
    endtask

    task automatic do_rot(input logic d, input logic [6:0] f, input logic [7:0] v, input logic c);
        logic [7:0] res;
        res = {c, v[7:1]};
        instr_in = {1'b1, 6'h0c, d, f};
        file_rdata_in = v;
        carry_in = c;
        @(posedge clk_sys_in);
        #2;
        `CHK("carry_we", 1'b1, carry_we_out)
        `CHK("carry", v[0], carry_out)
        `CHK("file_raddr", f, file_raddr_out)
        if (d == 1'b0) acc_m = res;
        `CHK("acc", acc_m, acc_out)
        `CHK("file_wr", (d ? {1'b1, f, res} : 1'b0), (d ? file_wr_out : file_wr_out.we))
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        #1ms;
        fails++;
        final_report();
    end

    initial begin
        void'($urandom(12139));
        do_reset();
        @(posedge clk_sys_in);
        #2;
        // Ten pushes wrap the eight-entry stack
        for (int i = 0; i < 10; i++) do_push(13'($urandom));
        for (int i = 0; i < 10; i++) begin
            do_ret(i % 2 == 0, (i == 0) ? 8'h00 : (i == 2) ? 8'hff : 8'($urandom), 2'($urandom));
        end
        // Back-to-back rotates, boundaries first
        do_rot(1'b1, 7'h7f, 8'he6, 1'b0);
        do_rot(1'b0, 7'h00, 8'he6, 1'b0);
        do_rot(1'b0, 7'h01, 8'h01, 1'b1);
        for (int i = 0; i < 40; i++) do_rot(1'($urandom), 7'($urandom), 8'($urandom), 1'($urandom));
        instr_in.valid = 1'b0;
        @(posedge clk_sys_in);
        #2;
        // Clock enable low holds a pending rotate back
        ce_in = 1'b0;
        instr_in = {1'b1, 6'h0c, 1'b1, 7'h11};
        file_rdata_in = 8'h81;
        carry_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #2;
        `CHK("frozen carry_we", 1'b0, carry_we_out)
        `CHK("frozen file_wr", 1'b0, file_wr_out.we)
        `CHK("frozen acc", acc_m, acc_out)
        ce_in = 1'b1;
        @(posedge clk_sys_in);
        #2;
        `CHK("enabled carry", 1'b1, carry_out)
        `CHK("enabled file_wr", {1'b1, 7'h11, 8'h40}, file_wr_out)
        instr_in.valid = 1'b0;
        @(posedge clk_sys_in);
        #2;
        // Pushes and pops mixed, then reset in mid-run clears the stack
        do_push(13'($urandom));
        do_push(13'($urandom));
        do_ret(1'b0, 8'h00, 2'b00);
        do_push(13'($urandom));
        do_ret(1'b1, 8'h5a, 2'b11);
        do_ret(1'b0, 8'h00, 2'b00);
        do_reset();
        @(posedge clk_sys_in);
        #2;
        do_ret(1'b0, 8'h00, 2'b00);
        final_report();
    end
endmodule
